// ===== rtl/pcr_calc.v
// error-plus-accumulation adder for the pid result mode
`timescale 1ns/1ps
`include "pcr_map.vh"
module pcr_calc (
  input wire [`PCR_PREV_ERR_W-1:0] error_i,
  input wire [`PCR_ACC_W-1:0] accum_i,
  output wire [`PCR_RESULT_W-1:0] sum_o
);
  // ==========================================================
  // two's complement sum, both operands sign extended to 36 bits
  wire [`PCR_RESULT_W-1:0] err_ext_w;
  wire [`PCR_RESULT_W-1:0] acc_ext_w;
  assign err_ext_w = {{19{error_i[16]}}, error_i};
  assign acc_ext_w = {accum_i[34], accum_i};
  assign sum_o = err_ext_w + acc_ext_w;
endmodule

// ===== rtl/pcr_map.vh
// register map, field layout and encodings of the coefficient/result block
`ifndef PCR_MAP_VH
`define PCR_MAP_VH

// ==========================================================
// byte addresses on the register bus
`define PCR_ADR_COEF_B_HIGH 8'h00
`define PCR_ADR_COEF_B_LOW 8'h04
`define PCR_ADR_COEF_C_HIGH 8'h08
`define PCR_ADR_COEF_C_LOW 8'h0c
`define PCR_ADR_RESULT_UPPER 8'h10
`define PCR_ADR_RESULT_HH 8'h14
`define PCR_ADR_RESULT_HL 8'h18
`define PCR_ADR_RESULT_LH 8'h1c
`define PCR_ADR_RESULT_LL 8'h20
`define PCR_ADR_PREV_ERR_UPPER 8'h24
`define PCR_ADR_PREV_ERR_HIGH 8'h28
`define PCR_ADR_PREV_ERR_LOW 8'h2c
`define PCR_ADR_STATUS 8'h30

// ==========================================================
// widths and fields
`define PCR_COEF_W 16
`define PCR_RESULT_W 36
`define PCR_PREV_ERR_W 17
`define PCR_ACC_W 35
`define PCR_RESULT_UPPER_W 4
`define PCR_STATUS_BUSY_BIT 0
`define PCR_STATUS_DONE_BIT 1

// ==========================================================
// reset values
`define PCR_BYTE_RST 8'h00
`define PCR_COEF_RST 16'h0000
`define PCR_RESULT_RST 36'h0_0000_0000
`define PCR_PREV_ERR_RST 17'h0_0000

// ==========================================================
// mode field encodings
`define PCR_MODE_PID 3'h5

`endif

// ===== rtl/pcr_top.v
// coefficient, result and history byte registers of the pid accelerator
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "pcr_map.vh"
// Function
// - coef_b held in high and low writable byte registers
// - coef_c held in high and low writable byte registers
// - on calculation completion the 36-bit result is captured
// - result upper register bits 7-4 read as zero
// - in pid mode keep 17-bit previous error term
// - previous error upper bits 7-1 read as zero
// - coef, result and history bits read/write; status busy read-only, done write-one-clear; all cleared by every reset
// - mode 101 result is current error plus accumulated errors
// - busy is high while a calculation runs
module pcr_top (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire en_i,
  input wire [2:0] mode_i,
  input wire start_i,
  input wire [16:0] error_i,
  input wire [34:0] accum_i,
  input wire [35:0] prod_result_i,
  input wire prod_done_i,
  output reg busy_o,
  output reg done_o,
  output reg [15:0] coef_b_o,
  output reg [15:0] coef_c_o,
  output reg [35:0] result_o,
  output reg [16:0] prev_error_o
);
  // ==========================================================
  // sequencer states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] mode_r;
  reg done_flag_r;

  wire wr_stb_w;
  wire rd_stb_w;
  wire [35:0] pid_sum_w;
  wire [7:0] wr_byte_w;
  wire finish_w;
  wire pid_mode_w;

  assign wr_byte_w = wb_dat_i[7:0];
  assign pid_mode_w = (mode_r == `PCR_MODE_PID);

  // ==========================================================
  // bus handshake
  pcr_wb_slave u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wr_stb_o(wr_stb_w),
    .rd_stb_o(rd_stb_w),
    .wb_ack_o(wb_ack_o)
  );

  // ==========================================================
  // pid-mode adder
  pcr_calc u_calc (
    .error_i(error_i),
    .accum_i(accum_i),
    .sum_o(pid_sum_w)
  );

  // ==========================================================
  // calculation sequence
  // the pid sum is ready one cycle after start; other modes wait
  // for the external multiplier to report completion
  assign finish_w = (state_r == ST_RUN) &&
                    (pid_mode_w || prod_done_i);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_i && en_i) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        // dropping the enable abandons the calculation
        if (!en_i) begin
          state_nxt = ST_IDLE;
        end else if (finish_w) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      mode_r <= 3'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && start_i && en_i) begin
        // mode is frozen for the whole calculation
        mode_r <= mode_i;
      end
      busy_o <= (state_nxt == ST_RUN);
      done_o <= (state_nxt == ST_DONE);
    end
  end

  // ==========================================================
  // coefficient registers
  // software supplies the gain combinations; the block stores them raw
  always @(posedge clk_i) begin
    if (rst_i) begin
      coef_b_o <= `PCR_COEF_RST;
      coef_c_o <= `PCR_COEF_RST;
    end else if (ce_i && wr_stb_w) begin
      if (wb_adr_i == `PCR_ADR_COEF_B_HIGH) begin
        coef_b_o[15:8] <= wr_byte_w;
      end else if (wb_adr_i == `PCR_ADR_COEF_B_LOW) begin
        coef_b_o[7:0] <= wr_byte_w;
      end else if (wb_adr_i == `PCR_ADR_COEF_C_HIGH) begin
        coef_c_o[15:8] <= wr_byte_w;
      end else if (wb_adr_i == `PCR_ADR_COEF_C_LOW) begin
        coef_c_o[7:0] <= wr_byte_w;
      end
    end
  end

  // ==========================================================
  // result registers
  // a completing calculation wins over a software write in the
  // same cycle, so a fresh result is never lost
  always @(posedge clk_i) begin
    if (rst_i) begin
      result_o <= `PCR_RESULT_RST;
    end else if (ce_i) begin
      if (finish_w && en_i) begin
        if (pid_mode_w) begin
          result_o <= pid_sum_w;
        end else begin
          result_o <= prod_result_i;
        end
      end else if (wr_stb_w) begin
        if (wb_adr_i == `PCR_ADR_RESULT_UPPER) begin
          result_o[35:32] <= wr_byte_w[3:0];
        end else if (wb_adr_i == `PCR_ADR_RESULT_HH) begin
          result_o[31:24] <= wr_byte_w;
        end else if (wb_adr_i == `PCR_ADR_RESULT_HL) begin
          result_o[23:16] <= wr_byte_w;
        end else if (wb_adr_i == `PCR_ADR_RESULT_LH) begin
          result_o[15:8] <= wr_byte_w;
        end else if (wb_adr_i == `PCR_ADR_RESULT_LL) begin
          result_o[7:0] <= wr_byte_w;
        end
      end
    end
  end

  // ==========================================================
  // previous-error history
  // only pid-mode iterations advance the history; the other modes
  // leave it for software to inspect or preload
  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_error_o <= `PCR_PREV_ERR_RST;
    end else if (ce_i) begin
      if (finish_w && en_i && pid_mode_w) begin
        prev_error_o <= error_i;
      end else if (wr_stb_w) begin
        if (wb_adr_i == `PCR_ADR_PREV_ERR_UPPER) begin
          prev_error_o[16] <= wr_byte_w[0];
        end else if (wb_adr_i == `PCR_ADR_PREV_ERR_HIGH) begin
          prev_error_o[15:8] <= wr_byte_w;
        end else if (wb_adr_i == `PCR_ADR_PREV_ERR_LOW) begin
          prev_error_o[7:0] <= wr_byte_w;
        end
      end
    end
  end

  // ==========================================================
  // sticky completion flag, write one to clear; a new completion
  // in the clearing cycle keeps the flag set
  always @(posedge clk_i) begin
    if (rst_i) begin
      done_flag_r <= 1'b0;
    end else if (ce_i) begin
      if (state_nxt == ST_DONE) begin
        done_flag_r <= 1'b1;
      end else if (wr_stb_w && wb_adr_i == `PCR_ADR_STATUS &&
                   wr_byte_w[`PCR_STATUS_DONE_BIT]) begin
        done_flag_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read back, registered with the ack; unmapped reads give zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i && rd_stb_w) begin
      if (wb_adr_i == `PCR_ADR_COEF_B_HIGH) begin
        wb_dat_o <= {24'h00_0000, coef_b_o[15:8]};
      end else if (wb_adr_i == `PCR_ADR_COEF_B_LOW) begin
        wb_dat_o <= {24'h00_0000, coef_b_o[7:0]};
      end else if (wb_adr_i == `PCR_ADR_COEF_C_HIGH) begin
        wb_dat_o <= {24'h00_0000, coef_c_o[15:8]};
      end else if (wb_adr_i == `PCR_ADR_COEF_C_LOW) begin
        wb_dat_o <= {24'h00_0000, coef_c_o[7:0]};
      end else if (wb_adr_i == `PCR_ADR_RESULT_UPPER) begin
        wb_dat_o <= {28'h000_0000, result_o[35:32]};
      end else if (wb_adr_i == `PCR_ADR_RESULT_HH) begin
        wb_dat_o <= {24'h00_0000, result_o[31:24]};
      end else if (wb_adr_i == `PCR_ADR_RESULT_HL) begin
        wb_dat_o <= {24'h00_0000, result_o[23:16]};
      end else if (wb_adr_i == `PCR_ADR_RESULT_LH) begin
        wb_dat_o <= {24'h00_0000, result_o[15:8]};
      end else if (wb_adr_i == `PCR_ADR_RESULT_LL) begin
        wb_dat_o <= {24'h00_0000, result_o[7:0]};
      end else if (wb_adr_i == `PCR_ADR_PREV_ERR_UPPER) begin
        wb_dat_o <= {31'h0000_0000, prev_error_o[16]};
      end else if (wb_adr_i == `PCR_ADR_PREV_ERR_HIGH) begin
        wb_dat_o <= {24'h00_0000, prev_error_o[15:8]};
      end else if (wb_adr_i == `PCR_ADR_PREV_ERR_LOW) begin
        wb_dat_o <= {24'h00_0000, prev_error_o[7:0]};
      end else if (wb_adr_i == `PCR_ADR_STATUS) begin
        wb_dat_o <= {30'h0000_0000, done_flag_r, busy_o};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end
endmodule

// ===== rtl/pcr_wb_slave.v
// classic wishbone handshake for the byte register file
`timescale 1ns/1ps
module pcr_wb_slave (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  output wire wr_stb_o,
  output wire rd_stb_o,
  output reg wb_ack_o
);
  // ==========================================================
  // request qualification
  // one access per request: the ack register blocks a second strobe
  wire req_w;
  assign req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
  // only lane 0 carries the byte registers
  assign wr_stb_o = req_w & wb_we_i & wb_sel_i[0];
  assign rd_stb_o = req_w & ~wb_we_i;

  // ==========================================================
  // ack, one cycle after the request is seen, dropped the next
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req_w;
    end
  end
endmodule

// ===== verif/pcr_top_monitor.sv
// bus and calculation assertions for the pid register block
`timescale 1ns/1ps
`include "pcr_map.vh"
module pcr_top_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire en_i,
  input wire [2:0] mode_i,
  input wire start_i,
  input wire [16:0] error_i,
  input wire [34:0] accum_i,
  input wire [35:0] prod_result_i,
  input wire prod_done_i,
  input wire busy_o,
  input wire done_o,
  input wire [15:0] coef_b_o,
  input wire [15:0] coef_c_o,
  input wire [35:0] result_o,
  input wire [16:0] prev_error_o
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  wire wr = tk && wb_we_i && wb_sel_i[0];
  wire run = busy_o && en_i && ce_i;
  // mode is latched at start, so the bench keeps it steady during a run
  wire pid = run && mode_i == `PCR_MODE_PID;
  wire [35:0] sum = {{19{error_i[16]}}, error_i} + {accum_i[34], accum_i};
  // ==========================================================
  // properties
  property p_ack; tk |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_kb; wr && wb_adr_i == `PCR_ADR_COEF_B_HIGH
    |=> coef_b_o[15:8] == $past(wb_dat_i[7:0]); endproperty
  a_kb: assert property (p_kb) else $error("coef_b high");
  property p_kc; wr && wb_adr_i == `PCR_ADR_COEF_C_LOW
    |=> coef_c_o[7:0] == $past(wb_dat_i[7:0]); endproperty
  a_kc: assert property (p_kc) else $error("coef_c low");
  property p_busy; !busy_o && !done_o && en_i && start_i && ce_i
    |=> busy_o; endproperty
  a_busy: assert property (p_busy) else $error("no busy");
  property p_done; done_o && ce_i |=> !done_o; endproperty
  a_done: assert property (p_done) else $error("done long");
  property p_pid; pid |=> done_o && !busy_o && result_o == $past(sum);
  endproperty
  a_pid: assert property (p_pid) else $error("pid sum");
  property p_hist; pid |=> prev_error_o == $past(error_i); endproperty
  a_hist: assert property (p_hist) else $error("history");
  property p_prod; run && prod_done_i && mode_i != `PCR_MODE_PID
    |=> done_o && result_o == $past(prod_result_i); endproperty
  a_prod: assert property (p_prod) else $error("product");
  property p_rst; disable iff (1'b0) rst_i |=> !busy_o && result_o == 0
    && prev_error_o == 0 && coef_b_o == 0 && coef_c_o == 0; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  cover property (wr);
  cover property (pid);
  cover property (run && prod_done_i);
endmodule
bind pcr_top pcr_top_monitor u_mon (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .en_i,
  .mode_i, .start_i, .error_i, .accum_i, .prod_result_i, .prod_done_i,
  .busy_o, .done_o, .coef_b_o, .coef_c_o, .result_o, .prev_error_o);

// ===== verif/pcr_top_test.sv
// self-checking bench for the pid coefficient, result and history bytes
`timescale 1ns/1ps
`include "pcr_map.vh"
module pcr_top_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic en_i = 1'b0;
  logic [2:0] mode_i = 3'h0;
  logic start_i = 1'b0;
  logic [16:0] error_i = 17'h0;
  logic [34:0] accum_i = 35'h0;
  logic [35:0] prod_result_i = 36'h0;
  logic prod_done_i = 1'b0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, busy_o, done_o;
  wire [15:0] coef_b_o, coef_c_o;
  wire [35:0] result_o;
  wire [16:0] prev_error_o;
  logic [31:0] q;
  int err_count = 0;
  int n_checks = 0;
  pcr_top DUT (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .en_i, .mode_i,
    .start_i, .error_i, .accum_i, .prod_result_i, .prod_done_i, .busy_o,
    .done_o, .coef_b_o, .coef_c_o, .result_o, .prev_error_o);
  initial forever #25 clk_i = ~clk_i;
  // ==========================================================
  // tasks
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [35:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // d selects what to wait for: done_o when set, wb_ack_o otherwise
  task automatic wait_for(input bit d);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((d ? done_o : wb_ack_o) !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      end_of_test;
    end
  endtask
  // one classic cycle; the master never assumes how soon ack comes
  task automatic wb(input logic w, input logic [7:0] a, d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wait_for(1'b0);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // byte written to register i, optionally masked to its implemented bits
  function automatic logic [7:0] pat(input int i, input bit m);
    pat = (8'(i * 4) ^ 8'hb7) & (!m ? 8'hff : i == 4 ? 8'h0f
      : i == 9 ? 8'h01 : 8'hff);
  endfunction
  task automatic chk_all(input bit z);
    for (int i = 0; i < 12; i++) begin
      wb(1'b0, 8'(i * 4), 8'h00);
      check("reg", q, z ? 36'h0 : 36'(pat(i, 1)));
    end
  endtask
  task automatic run(input logic [2:0] m, input logic [16:0] e,
    input logic [34:0] a, input logic [35:0] p, r, input logic [16:0] h);
    @(posedge clk_i);
    mode_i <= m;
    error_i <= e;
    accum_i <= a;
    prod_result_i <= p;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    @(posedge clk_i);
    check("busy", busy_o, 1'b1);
    prod_done_i <= (m != `PCR_MODE_PID);
    wait_for(1'b1);
    prod_done_i <= 1'b0;
    check("done", done_o, 1'b1);
    check("busy end", busy_o, 1'b0);
    check("result", result_o, r);
    check("history", prev_error_o, 36'(h));
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    en_i <= 1'b1;
    chk_all(1'b1);
    for (int i = 0; i < 12; i++) wb(1'b1, 8'(i * 4), pat(i, 1'b0));
    chk_all(1'b0);
    check("coef_b", coef_b_o, {pat(0, 0), pat(1, 0)});
    check("coef_c", coef_c_o, {pat(2, 0), pat(3, 0)});
    check("result", result_o, 36'({pat(4, 1), pat(5, 1), pat(6, 1),
      pat(7, 1), pat(8, 1)}));
    check("history", prev_error_o, 36'(17'({pat(9, 1), pat(10, 1),
      pat(11, 1)})));
    wb(1'b1, 8'h34, 8'h5a);
    wb(1'b0, 8'h34, 8'h00);
    check("unmapped", q, 36'h0);
    run(`PCR_MODE_PID, 17'h1_fffe, 35'h5, 36'h0, 36'h3, 17'h1_fffe);
    // sticky done flag in bit 1, busy in bit 0, write one clears done
    wb(1'b0, `PCR_ADR_STATUS, 8'h00);
    check("status", q, 36'h2);
    wb(1'b1, `PCR_ADR_STATUS, 8'h02);
    wb(1'b0, `PCR_ADR_STATUS, 8'h00);
    check("status clear", q, 36'h0);
    run(`PCR_MODE_PID, 17'h0_7fff, 35'h7_ffff_ffff, 36'h0, 36'h7ffe,
      17'h0_7fff);
    // sign extension of both operands matters only for negative values
    run(`PCR_MODE_PID, 17'h1_0000, 35'h4_0000_0000, 36'h0,
      36'hb_ffff_0000, 17'h1_0000);
    wb(1'b0, `PCR_ADR_RESULT_UPPER, 8'h00);
    check("result upper", q, 36'hb);
    run(3'h2, 17'h0_1234, 35'h0, 36'h9_8765_4321, 36'h9_8765_4321,
      17'h1_0000);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    chk_all(1'b1);
    end_of_test;
  end
endmodule
